// ### core/foc_map.svh
// register map, field positions, reset values and counts of the
// frequency offset compensation control block.
// assumes an 8-bit register port with byte-wide registers.
`ifndef FOC_MAP_SVH
`define FOC_MAP_SVH

// register addresses
`define FOC_ADDR_RADIO_SM 8'h18
`define FOC_ADDR_FREQ_COMP 8'h19
`define FOC_ADDR_STATUS 8'h1a
`define FOC_ADDR_CORR_LO 8'h1b
`define FOC_ADDR_CORR_HI 8'h1c

// radio state machine configuration fields
`define FOC_AUTOCAL_LSB 4
`define FOC_POWAIT_LSB 2
`define FOC_PINEN_BIT 1
`define FOC_KEEP_BIT 0
`define FOC_RADIO_SM_RST 8'h04
`define FOC_RADIO_SM_MASK 8'h3f

// frequency compensation configuration fields
`define FOC_FREEZE_BIT 5
`define FOC_PRE_LSB 3
`define FOC_POST_BIT 2
`define FOC_SAT_LSB 0
`define FOC_FREQ_COMP_RST 8'h36
`define FOC_FREQ_COMP_MASK 8'h3f

// status fields
`define FOC_ST_READY_BIT 0
`define FOC_ST_FROZEN_BIT 1
`define FOC_ST_SYNC_BIT 2
`define FOC_ST_ASKSAT_BIT 3
`define FOC_ST_PINACT_BIT 4

// power-on wait: ripple counter width and expirations per setting
`define FOC_RIPPLE_W 6
`define FOC_EXP_SET0 9'h001
`define FOC_EXP_SET1 9'h010
`define FOC_EXP_SET2 9'h040
`define FOC_EXP_SET3 9'h100

`endif

// ### core/foc_pkg.sv
// types shared by the frequency offset compensation control files.
// takes no value from foc_map.svh; the state codes are set here.
package foc_pkg;

   // power-on wait sequencer, gray along wait -> count -> ready
   typedef enum logic [1:0] {
      FOC_POR_WAIT_XTAL = 2'b00,
      FOC_POR_COUNT = 2'b01,
      FOC_POR_READY = 2'b11
   } foc_por_state_t;

   // software loop configuration as held in the register
   typedef struct packed {
      logic freeze_gate;
      logic [1:0] gain_pre;
      logic gain_post;
      logic [1:0] saturation;
   } foc_loop_cfg_t;

   // loop steering handed to the demodulator
   typedef struct packed {
      logic freeze;
      logic comp_enable;
      logic [3:0] gain_half_k;
      logic [1:0] sat_shift;
   } foc_loop_ctl_t;

endpackage

// ### core/foc_por_wait.sv
// power-on wait sequencer: counts ripple counter expirations after
// the crystal is stable, then pulls chip_ready_n low.
// assumes crystal_stable is already synchronised to clock.
`include "foc_map.svh"
`timescale 1ns/1ns
module foc_por_wait #(
   parameter int RIPPLE_W = `FOC_RIPPLE_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic crystal_stable,
   input wire logic [1:0] wait_sel,
   output logic chip_ready_n
);

   foc_pkg::foc_por_state_t state, next_state;
   logic [RIPPLE_W-1:0] ripple;
   logic [8:0] expired;
   logic [8:0] target;
   logic ripple_done;

   assign ripple_done = &ripple;

   always_comb begin
      case (wait_sel)
         2'h0: target = `FOC_EXP_SET0;
         2'h1: target = `FOC_EXP_SET1;
         2'h2: target = `FOC_EXP_SET2;
         default: target = `FOC_EXP_SET3;
      endcase
   end

   always_comb begin
      next_state = state;
      case (state)
         foc_pkg::FOC_POR_WAIT_XTAL: begin
            if (crystal_stable) begin
               next_state = foc_pkg::FOC_POR_COUNT;
            end
         end
         foc_pkg::FOC_POR_COUNT: begin
            if (!crystal_stable) begin
               next_state = foc_pkg::FOC_POR_WAIT_XTAL;
            end else if (ripple_done && (expired + 9'h001) >= target) begin
               next_state = foc_pkg::FOC_POR_READY;
            end
         end
         foc_pkg::FOC_POR_READY: begin
            if (!crystal_stable) begin
               next_state = foc_pkg::FOC_POR_WAIT_XTAL;
            end
         end
         default: next_state = foc_pkg::FOC_POR_WAIT_XTAL;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= foc_pkg::FOC_POR_WAIT_XTAL;
      end else begin
         state <= next_state;
      end
   end

   // ripple counter and expiration tally only run while counting
   always_ff @(posedge clock) begin
      if (rst || state != foc_pkg::FOC_POR_COUNT) begin
         ripple <= '0;
         expired <= 9'h000;
      end else begin
         ripple <= ripple + 1'b1;
         if (ripple_done) begin
            expired <= expired + 9'h001;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         chip_ready_n <= 1'b1;
      end else begin
         chip_ready_n <= (next_state != foc_pkg::FOC_POR_READY);
      end
   end

endmodule

// ### core/foc_loop_ctl.sv
// maps the loop configuration and receiver events onto gain,
// saturation and freeze controls for the demodulator.
// assumes carrier_sense and sync_seen come from logic on clock.
`include "foc_map.svh"
`timescale 1ns/1ns
module foc_loop_ctl (
   input wire logic clock,
   input wire logic rst,
   input wire foc_pkg::foc_loop_cfg_t cfg,
   input wire logic carrier_sense,
   input wire logic sync_seen,
   output foc_pkg::foc_loop_ctl_t ctl
);

   foc_pkg::foc_loop_ctl_t next_ctl;
   logic [2:0] pre_mult;

   // pre-sync gain in units of K/2: K, 2K, 3K, 4K -> 2, 4, 6, 8
   assign pre_mult = {1'b0, cfg.gain_pre} + 3'h1;

   always_comb begin
      next_ctl.freeze = cfg.freeze_gate && !carrier_sense;
      next_ctl.comp_enable = (cfg.saturation != 2'h0);
      if (sync_seen && cfg.gain_post) begin
         next_ctl.gain_half_k = 4'h1;
      end else begin
         next_ctl.gain_half_k = {pre_mult, 1'b0};
      end
      case (cfg.saturation)
         2'h1: next_ctl.sat_shift = 2'h3;
         2'h2: next_ctl.sat_shift = 2'h2;
         2'h3: next_ctl.sat_shift = 2'h1;
         default: next_ctl.sat_shift = 2'h0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctl <= '0;
      end else begin
         ctl <= next_ctl;
      end
   end

endmodule

// ### core/foc_ctrl.sv
// top of the frequency offset compensation control block: register
// port, power-on wait, pin radio control gate and the offset loop.
// assumes one 20 MHz crystal-derived clock and a synchronous reset;
// demodulator events arrive on the same clock, pins do not.
//
// Chosen here: the plain strobed port.
`include "foc_map.svh"
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////
// Function
// - Power-on wait settings 2 and 3 require 64 and 256 ripple counter expirations before chip ready.
// - Power-on wait settings 0 and 1 require 1 and 16 expirations after crystal start before chip_ready_n falls.
// - Pin radio control is accepted only while its enable bit is set, and the bit resets clear.
// - With the freeze bit set both offset and clock recovery loops stay frozen until carrier sense is high; it resets to 1.
// - Before sync the loop gain is K, 2K, 3K or 4K from the two-bit pre-sync field.
// - After sync the post-sync bit keeps the pre-sync gain when 0 and selects K/2 when 1.
// - The saturation field disables compensation at 0 and limits offset to bandwidth over 8, 4, 2.
// - Reset values are pre-sync gain 2, post-sync bit 1 and saturation 2.
module foc_ctrl #(
   parameter int OFFSET_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic crystal_stable,
   input wire logic [1:0] pin_radio_in,
   input wire logic carrier_sense,
   input wire logic sync_detected,
   input wire logic rx_restart,
   input wire logic ask_selected,
   input wire logic offset_valid,
   input wire logic signed [OFFSET_W-1:0] offset_error,
   input wire logic [OFFSET_W-1:0] channel_bandwidth,
   output logic chip_ready_n,
   output logic [1:0] autocal_mode,
   output logic crystal_keep_alive,
   output logic [1:0] pin_radio_cmd,
   output logic pin_ctrl_active,
   output foc_pkg::foc_loop_ctl_t loop_ctl,
   output logic signed [OFFSET_W-1:0] freq_correction
);

   localparam int SUM_W = OFFSET_W + 5;

   logic [7:0] radio_state_machine_config;
   logic [7:0] freq_offset_comp_config;
   foc_pkg::foc_loop_cfg_t loop_cfg;
   logic [1:0] power_on_wait_count;
   logic pin_ctrl_enable;

   logic xtal_meta;
   logic xtal_sync;
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;

   logic sync_seen;
   logic chip_ready_int;
   logic ask_sat_conflict;

   logic signed [OFFSET_W+4:0] step;
   logic signed [SUM_W-1:0] sum;
   logic signed [SUM_W-1:0] limit_pos;
   logic signed [SUM_W-1:0] limit_neg;
   logic signed [SUM_W-1:0] next_sum;
   logic [OFFSET_W-1:0] limit_mag;

   logic wr_radio;
   logic wr_freq;

   ////////////////////////////////////////////////////////////////
   // configuration registers

   assign wr_radio = reg_write && (reg_addr == `FOC_ADDR_RADIO_SM);
   assign wr_freq = reg_write && (reg_addr == `FOC_ADDR_FREQ_COMP);

   always_ff @(posedge clock) begin
      if (rst) begin
         radio_state_machine_config <= `FOC_RADIO_SM_RST;
      end else if (wr_radio) begin
         radio_state_machine_config <= reg_wdata & `FOC_RADIO_SM_MASK;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         freq_offset_comp_config <= `FOC_FREQ_COMP_RST;
      end else if (wr_freq) begin
         freq_offset_comp_config <= reg_wdata & `FOC_FREQ_COMP_MASK;
      end
   end

   assign autocal_mode = radio_state_machine_config[`FOC_AUTOCAL_LSB +: 2];
   assign power_on_wait_count = radio_state_machine_config[`FOC_POWAIT_LSB +: 2];
   assign pin_ctrl_enable = radio_state_machine_config[`FOC_PINEN_BIT];
   assign crystal_keep_alive = radio_state_machine_config[`FOC_KEEP_BIT];

   assign loop_cfg.freeze_gate = freq_offset_comp_config[`FOC_FREEZE_BIT];
   assign loop_cfg.gain_pre = freq_offset_comp_config[`FOC_PRE_LSB +: 2];
   assign loop_cfg.gain_post = freq_offset_comp_config[`FOC_POST_BIT];
   assign loop_cfg.saturation = freq_offset_comp_config[`FOC_SAT_LSB +: 2];

   ////////////////////////////////////////////////////////////////
   // pin synchronisers

   // the crystal detector is analog and the pins are asynchronous
   always_ff @(posedge clock) begin
      if (rst) begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
      end else begin
         xtal_meta <= crystal_stable;
         xtal_sync <= xtal_meta;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
      end else begin
         pin_meta <= pin_radio_in;
         pin_sync <= pin_meta;
      end
   end

   ////////////////////////////////////////////////////////////////
   // power-on wait

   foc_por_wait #(
      .RIPPLE_W(`FOC_RIPPLE_W)
   ) u_por_wait (
      .clock(clock),
      .rst(rst),
      .crystal_stable(xtal_sync),
      .wait_sel(power_on_wait_count),
      .chip_ready_n(chip_ready_n)
   );

   assign chip_ready_int = !chip_ready_n;

   ////////////////////////////////////////////////////////////////
   // pin radio control

   // pins are ignored until the chip is ready so a floating pin at
   // power-up cannot start the radio
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_radio_cmd <= 2'h0;
      end else if (pin_ctrl_enable && chip_ready_int) begin
         pin_radio_cmd <= pin_sync;
      end else begin
         pin_radio_cmd <= 2'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pin_ctrl_active <= 1'b0;
      end else begin
         pin_ctrl_active <= pin_ctrl_enable && chip_ready_int;
      end
   end

   ////////////////////////////////////////////////////////////////
   // sync word tracking

   // a sync in the same cycle as a restart wins: the new packet counts
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_seen <= 1'b0;
      end else if (sync_detected) begin
         sync_seen <= 1'b1;
      end else if (rx_restart) begin
         sync_seen <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // loop steering

   foc_loop_ctl u_loop_ctl (
      .clock(clock),
      .rst(rst),
      .cfg(loop_cfg),
      .carrier_sense(carrier_sense),
      .sync_seen(sync_seen),
      .ctl(loop_ctl)
   );

   // compensation is not forced off here; software owns that choice,
   // the block only reports the conflict
   always_ff @(posedge clock) begin
      if (rst) begin
         ask_sat_conflict <= 1'b0;
      end else begin
         ask_sat_conflict <= ask_selected && (loop_cfg.saturation != 2'h0);
      end
   end

   ////////////////////////////////////////////////////////////////
   // offset accumulator with saturation

   // gain is in half-K steps, so the product is halved afterwards
   // widen before the product so a full-scale error times 4K cannot wrap
   assign step = (SUM_W'(offset_error) * $signed({1'b0, loop_ctl.gain_half_k})) >>> 1;
   assign sum = SUM_W'(freq_correction) + SUM_W'(step);
   assign limit_mag = channel_bandwidth >> loop_ctl.sat_shift;
   assign limit_pos = $signed(SUM_W'(limit_mag));
   assign limit_neg = -limit_pos;

   always_comb begin
      if (sum > limit_pos) begin
         next_sum = limit_pos;
      end else if (sum < limit_neg) begin
         next_sum = limit_neg;
      end else begin
         next_sum = sum;
      end
   end

   // limit may be wider than the output when bandwidth is near full
   // scale; the clamp keeps the stored value inside OFFSET_W bits
   always_ff @(posedge clock) begin
      if (rst || rx_restart || !loop_ctl.comp_enable) begin
         freq_correction <= '0;
      end else if (offset_valid && !loop_ctl.freeze) begin
         freq_correction <= OFFSET_W'(next_sum);
      end
   end

   ////////////////////////////////////////////////////////////////
   // register read port

   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            `FOC_ADDR_RADIO_SM: reg_rdata <= radio_state_machine_config;
            `FOC_ADDR_FREQ_COMP: reg_rdata <= freq_offset_comp_config;
            `FOC_ADDR_STATUS: begin
               reg_rdata <= 8'h00;
               reg_rdata[`FOC_ST_READY_BIT] <= chip_ready_int;
               reg_rdata[`FOC_ST_FROZEN_BIT] <= loop_ctl.freeze;
               reg_rdata[`FOC_ST_SYNC_BIT] <= sync_seen;
               reg_rdata[`FOC_ST_ASKSAT_BIT] <= ask_sat_conflict;
               reg_rdata[`FOC_ST_PINACT_BIT] <= pin_ctrl_active;
            end
            `FOC_ADDR_CORR_LO: reg_rdata <= freq_correction[7:0];
            `FOC_ADDR_CORR_HI: reg_rdata <= freq_correction[15:8];
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule

// ### tb/foc_ctrl_chk.sv
// port-level checker for the offset compensation control top.
// assumes the clock and synchronous reset of foc_ctrl, bound below.
`timescale 1ns/1ns
module foc_ctrl_chk #(
   parameter int OFFSET_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic crystal_stable,
   input wire logic carrier_sense,
   input wire logic sync_detected,
   input wire logic rx_restart,
   input wire logic chip_ready_n,
   input wire logic [1:0] pin_radio_cmd,
   input wire logic pin_ctrl_active,
   input wire foc_pkg::foc_loop_ctl_t loop_ctl,
   input wire logic signed [OFFSET_W-1:0] freq_correction
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////
   // no write around the sync pulse, so only the sync moves the gain
   sequence s_sync_quiet;
      !reg_write ##1 sync_detected && !reg_write ##1 !reg_write;
   endsequence
   sequence s_xtal_gone;
      !crystal_stable [*4];
   endsequence
   property p_rd_idle;
      !reg_read |=> reg_rdata == 8'h00;
   endproperty
   property p_rd_unused;
      reg_read && (reg_addr == 8'h19) |=> reg_rdata[7:6] == 2'b00;
   endproperty
   property p_pin_off;
      reg_write && reg_addr == 8'h18 && !reg_wdata[1] |=> ##2 !pin_ctrl_active;
   endproperty
   property p_pin_gate;
      !pin_ctrl_active |-> pin_radio_cmd == 2'b00;
   endproperty
   property p_carrier_thaw;
      carrier_sense |=> !loop_ctl.freeze;
   endproperty
   property p_frozen_hold;
      loop_ctl.freeze && !rx_restart && !reg_write |=> $stable(freq_correction);
   endproperty
   property p_post_gain;
      s_sync_quiet |=> loop_ctl.gain_half_k == 4'h1 ||
         loop_ctl.gain_half_k == $past(loop_ctl.gain_half_k, 2);
   endproperty
   property p_comp_off;
      !loop_ctl.comp_enable |=> freq_correction == '0;
   endproperty
   property p_ready_drop;
      s_xtal_gone |=> chip_ready_n;
   endproperty
   property p_ready_late;
      $fell(chip_ready_n) |-> $past(crystal_stable, 60);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   a_rd_unused: assert property (p_rd_unused) else $error("unused bits set");
   a_pin_off: assert property (p_pin_off) else $error("pin control stays on");
   a_pin_gate: assert property (p_pin_gate) else $error("pin command leaks");
   a_carrier_thaw: assert property (p_carrier_thaw) else $error("loop frozen");
   a_frozen_hold: assert property (p_frozen_hold) else $error("moved while frozen");
   a_post_gain: assert property (p_post_gain) else $error("bad post gain");
   a_comp_off: assert property (p_comp_off) else $error("correction kept");
   a_ready_drop: assert property (p_ready_drop) else $error("ready without xtal");
   a_ready_late: assert property (p_ready_late) else $error("ready too early");
endmodule
bind foc_ctrl foc_ctrl_chk #(.OFFSET_W(OFFSET_W)) i_foc_ctrl_chk (.clock(clock), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .crystal_stable(crystal_stable), .carrier_sense(carrier_sense),
   .sync_detected(sync_detected), .rx_restart(rx_restart), .chip_ready_n(chip_ready_n),
   .pin_radio_cmd(pin_radio_cmd), .pin_ctrl_active(pin_ctrl_active),
   .loop_ctl(loop_ctl), .freq_correction(freq_correction));

// ### tb/foc_ctrl_tb_top.sv
// self-checking bench for foc_ctrl: registers, loop table, power-on wait, pins.
// assumes a 20 MHz clock and channel bandwidth fixed at 0x0800.
`timescale 1ns/1ns
module foc_ctrl_tb_top;
   typedef struct packed {
      logic [7:0] cfg;
      logic cs;
      logic sy;
      logic [15:0] err;
      logic [3:0] n;
      logic [7:0] ctl;
      logic [15:0] corr;
   } foc_row_t;
   logic clock = 0, rst = 1, reg_write = 0, reg_read = 0, crystal_stable = 0;
   logic carrier_sense = 0, sync_detected = 0, rx_restart = 0, ask_selected = 0;
   logic offset_valid = 0, chip_ready_n, crystal_keep_alive, pin_ctrl_active;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [1:0] pin_radio_in = 2'b10, autocal_mode, pin_radio_cmd;
   logic signed [15:0] offset_error = 0, freq_correction;
   logic [15:0] channel_bandwidth = 16'h0800;
   foc_pkg::foc_loop_ctl_t loop_ctl;
   int n_mismatch = 0, total_checks = 0, cyc = 0, t;
   int exp_n[4] = '{1, 16, 64, 256};
   // limits with bw 0x0800: sat 1 -> 0x100, 2 -> 0x200, 3 -> 0x400
   foc_row_t rows[8] = '{
      '{8'h01, 1'b0, 1'b0, 16'h0010, 4'h1, 8'h4b, 16'h0010},
      '{8'h0a, 1'b0, 1'b0, 16'h0010, 4'h2, 8'h52, 16'h0040},
      '{8'h13, 1'b0, 1'b0, 16'hfff0, 4'h1, 8'h59, 16'hffd0},
      '{8'h1b, 1'b0, 1'b0, 16'h0400, 4'h2, 8'h61, 16'h0400},
      '{8'h1d, 1'b0, 1'b1, 16'h0010, 4'h1, 8'h47, 16'h0008},
      '{8'h19, 1'b0, 1'b1, 16'hfc00, 4'h2, 8'h63, 16'hff00},
      '{8'h36, 1'b0, 1'b0, 16'h0010, 4'h2, 8'hda, 16'h0000},
      '{8'h36, 1'b1, 1'b0, 16'h0010, 4'h1, 8'h5a, 16'h0030}};
   foc_ctrl i_foc_ctrl (.clock(clock), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .crystal_stable(crystal_stable), .pin_radio_in(pin_radio_in),
      .carrier_sense(carrier_sense), .sync_detected(sync_detected),
      .rx_restart(rx_restart), .ask_selected(ask_selected), .offset_valid(offset_valid),
      .offset_error(offset_error), .channel_bandwidth(channel_bandwidth),
      .chip_ready_n(chip_ready_n), .autocal_mode(autocal_mode),
      .crystal_keep_alive(crystal_keep_alive), .pin_radio_cmd(pin_radio_cmd),
      .pin_ctrl_active(pin_ctrl_active), .loop_ctl(loop_ctl),
      .freq_correction(freq_correction));
   initial forever #25 clock = ~clock;
   ////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_read <= 1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 0;
      #1 chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // generous ceiling: the longest wait alone is 16384 cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clock);
      rst <= 0;
      wait_cyc(1);
      chk("loop_ctl", loop_ctl, 16'h00da);
      rdc(8'h18, 8'h04);
      rdc(8'h19, 8'h36);
      rdc(8'h40, 8'h00);
      wr(8'h19, 8'hff);
      rdc(8'h19, 8'h3f);
      wr(8'h18, 8'hff);
      rdc(8'h18, 8'h3f);
      chk("autocal_keep", {autocal_mode, crystal_keep_alive}, 16'h0007);
      $display("register test done");
      foreach (rows[i]) begin
         @(posedge clock);
         rx_restart <= 1;
         carrier_sense <= rows[i].cs;
         @(posedge clock);
         rx_restart <= 0;
         wr(8'h19, rows[i].cfg);
         wait_cyc(3);
         if (rows[i].sy) begin
            @(posedge clock);
            sync_detected <= 1;
            @(posedge clock);
            sync_detected <= 0;
         end
         wait_cyc(3);
         chk("loop_ctl", loop_ctl, {8'h00, rows[i].ctl});
         repeat (rows[i].n) begin
            @(posedge clock);
            offset_valid <= 1;
            offset_error <= rows[i].err;
            @(posedge clock);
            offset_valid <= 0;
         end
         wait_cyc(2);
         chk("freq_correction", freq_correction, rows[i].corr);
         $display("loop row %0d done", i);
      end
      // keyed modulation with saturation still on is only flagged
      ask_selected <= 1;
      wr(8'h19, 8'h35);
      wait_cyc(2);
      rdc(8'h1a, 8'h08);
      // keyed modulation: software turns compensation off first
      wr(8'h19, 8'h34);
      ask_selected <= 1;
      @(posedge clock);
      offset_valid <= 1;
      @(posedge clock);
      offset_valid <= 0;
      wait_cyc(3);
      chk("comp_off", {loop_ctl.comp_enable, freq_correction}, 16'h0000);
      $display("saturation off test done");
      for (int s = 0; s < 4; s++) begin
         @(posedge clock);
         crystal_stable <= 0;
         wr(8'h18, 8'(s << 2));
         wait_cyc(6);
         chk("chip_ready_n", chip_ready_n, 16'h0001);
         @(posedge clock);
         crystal_stable <= 1;
         t = 0;
         while (chip_ready_n !== 1'b0 && t < 64 * exp_n[s] + 20) begin
            wait_cyc(1);
            t++;
         end
         chk("ready_time_ok", 16'(t >= 64 * exp_n[s] && t <= 64 * exp_n[s] + 8), 1);
         $display("power-on wait setting %0d done after %0d cycles", s, t);
      end
      wr(8'h18, 8'h0c);
      wait_cyc(5);
      chk("pins", {pin_ctrl_active, pin_radio_cmd}, 16'h0000);
      wr(8'h18, 8'h0e);
      wait_cyc(5);
      chk("pins", {pin_ctrl_active, pin_radio_cmd}, 16'h0006);
      pin_radio_in <= 2'b01;
      wait_cyc(5);
      chk("pins", {pin_ctrl_active, pin_radio_cmd}, 16'h0005);
      wr(8'h18, 8'h0c);
      wait_cyc(3);
      chk("pins", {pin_ctrl_active, pin_radio_cmd}, 16'h0000);
      crystal_stable <= 0;
      wait_cyc(6);
      chk("ready_pins", {chip_ready_n, pin_ctrl_active}, 16'h0002);
      $display("pin control test done");
      close_out();
   end
endmodule
